// [csf_pkg.sv]
// package for codec status flags and multipurpose pin mux
package csf_pkg;
  localparam logic [7:0] ADDR_SHORT_STATUS = 8'h5F;
  localparam logic [7:0] ADDR_RT_FLAGS = 8'h61;
  localparam logic [7:0] ADDR_PIN1_CTRL = 8'h62;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h70;
  localparam logic [7:0] ADDR_INT_MASK = 8'h71;
  localparam logic [7:0] ADDR_BUTTON_CLEAR = 8'h0E;
  localparam logic [7:0] ADDR_INT_FLAGS_READ = 8'h60;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] FN_DISABLED = 4'h0;
  localparam logic [3:0] FN_CONV_WCLK = 4'h1;
  localparam logic [3:0] FN_DIV1 = 4'h2;
  localparam logic [3:0] FN_DIV2 = 4'h3;
  localparam logic [3:0] FN_DIV4 = 4'h4;
  localparam logic [3:0] FN_DIV8 = 4'h5;
  localparam logic [3:0] FN_SHORT_INT = 4'h6;
  localparam logic [3:0] FN_NOISE_INT = 4'h7;
  localparam logic [3:0] FN_GP_IN = 4'h8;
  localparam logic [3:0] FN_GP_OUT = 4'h9;
  localparam logic [3:0] FN_BUS_WCLK = 4'hB;
  localparam logic [3:0] FN_BUTTON_INT = 4'hC;
  localparam logic [3:0] FN_HEADSET_INT = 4'hD;
  localparam logic [3:0] FN_HS_OR_BTN = 4'hE;
  localparam logic [3:0] FN_ALL_INT = 4'hF;
  localparam int FN_HI = 7;
  localparam int FN_LO = 4;
  localparam int WCLK_DIR_BIT = 3;
  localparam int DUR_BIT = 2;
  localparam int GPI_BIT = 1;
  localparam int GPO_BIT = 0;
  localparam int BTN_BIT = 3;
  localparam int HS_BIT = 2;
  // interrupt status layout
  localparam int EV_SHORT = 0;
  localparam int EV_HEADSET = 1;
  localparam int EV_BUTTON = 2;
  localparam int EV_NOISE = 3;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int PULSE_US = 2000;
  localparam int PULSE_CYC = CLOCK_HZ / 1_000_000 * PULSE_US;
  localparam int GAP_CYC = PULSE_CYC;
  typedef struct packed {
    logic [3:0] short_det;
    logic left_common_power;
    logic right_common_power;
    logic headset;
    logic button;
    logic [1:0] noise_gate;
  } csf_analog_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } csf_bus_t;
endpackage : csf_pkg

// [csf_top.sv]
// status flags, interrupt logic and multipurpose pin one selector
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
// Function
// - short status bits 7..4 show shorts at left/right headphone and left/right common drivers.
// - short status bits 3 and 2 show the left and right common drivers fully powered up.
// - the two lowest short status bits read zero and the host never writes them.
// - real-time flag bits 7..4 show the present short condition of the four drivers.
// - real-time bit 3 is a sticky button press, cleared only by a read of register 14.
// - real-time bit 2 reads one while a headset is detected.
// - real-time bits 1 and 0 read one while left and right signal power is under the noise threshold.
// - pin function field bits 7..4 resets to 0000 (pin off) and 0001 carries the converter word clock.
// - codes 0010 to 0101 drive the pin with the clock mux output divided by 1, 2, 4 and 8.
// - code 0110 gives the short interrupt; the noise interrupt code is taken as 0111 pending confirmation.
// - code 1000 makes the pin a general input and 1001 a general output.
// - code 1011 makes the pin the bus word clock, direction chosen by a control bit.
// - code 1100 gives the active-high button interrupt, following the debounced press.
// - codes 1101, 1110 and 1111 give headset, headset or button, and the OR of all four interrupts.
// - a duration bit picks one 2 ms pulse or repeated pulses until register 96 is read.
module csf_top #(
  parameter int PULSE_CYCLES = csf_pkg::PULSE_CYC
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // detector inputs, asynchronous
  input wire csf_pkg::csf_analog_t ANALOG,
  // clock sources
  input wire logic CLOCK_MUX_IN,
  input wire logic CONV_WCLK_IN,
  input wire logic BUS_WCLK_IN,
  // multipurpose pin one
  input wire logic PIN1_I,
  output logic PIN1_O,
  output logic PIN1_OE,
  // word clock received on the pin
  output logic BUS_WCLK_OUT,
  // interrupt
  output logic IRQ
);
  initial begin
    if (PULSE_CYCLES < 2) $error("PULSE_CYCLES too small");
  end

  // two-flop synchronisers on every asynchronous input
  localparam int NSYNC = $bits(csf_pkg::csf_analog_t) + 4;
  logic [NSYNC-1:0] s1_q, s2_q;
  wire [NSYNC-1:0] raw_in = {ANALOG, CLOCK_MUX_IN, CONV_WCLK_IN, BUS_WCLK_IN, PIN1_I};
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end
  csf_pkg::csf_analog_t an;
  logic mux_clk, conv_wclk, bus_wclk, pin_in;
  assign {an, mux_clk, conv_wclk, bus_wclk, pin_in} = s2_q;

  // bus decode
  wire hit_short = ADDR == csf_pkg::ADDR_SHORT_STATUS;
  wire hit_rt = ADDR == csf_pkg::ADDR_RT_FLAGS;
  wire hit_pin = ADDR == csf_pkg::ADDR_PIN1_CTRL;
  wire hit_ist = ADDR == csf_pkg::ADDR_INT_STATUS;
  wire hit_imask = ADDR == csf_pkg::ADDR_INT_MASK;
  wire wr_pin = WR && hit_pin;
  wire wr_ist = WR && hit_ist;
  wire wr_imask = WR && hit_imask;
  wire rd_btn_clr = RD && ADDR == csf_pkg::ADDR_BUTTON_CLEAR;
  wire rd_int_flags = RD && ADDR == csf_pkg::ADDR_INT_FLAGS_READ;

  // control register
  logic [7:0] ctrl_q;
  logic [3:0] imask_q;
  logic [3:0] ist_q;
  logic btn_sticky_q;
  wire [3:0] fn = ctrl_q[csf_pkg::FN_HI:csf_pkg::FN_LO];
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_q <= csf_pkg::RESET_BYTE;
      imask_q <= '0;
    end else begin
      if (wr_pin) ctrl_q <= {WDATA[7:2], 1'b0, WDATA[csf_pkg::GPO_BIT]};
      if (wr_imask) imask_q <= WDATA[3:0];
    end
  end

  // sticky button flag: set wins over the clearing read
  wire btn_clear = rd_btn_clr && !an.button;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) btn_sticky_q <= 1'b0;
    else if (an.button) btn_sticky_q <= 1'b1;
    else if (btn_clear) btn_sticky_q <= 1'b0;
  end

  // event edges for the interrupt status register
  logic [3:0] lvl_q;
  wire short_any = |an.short_det;
  wire noise_any = |an.noise_gate;
  wire [3:0] lvl = {noise_any, an.button, an.headset, short_any};
  wire [3:0] rise = lvl & ~lvl_q;
  wire [3:0] ist_d = rise | (ist_q & ~(wr_ist ? WDATA[3:0] : 4'h0));
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      lvl_q <= '0;
      ist_q <= '0;
    end else begin
      lvl_q <= lvl;
      ist_q <= ist_d;
    end
  end

  // read mux; read-only registers have no write path
  wire [7:0] short_reg = {an.short_det, an.left_common_power, an.right_common_power, 2'b00};
  wire [7:0] rt_reg = {an.short_det, btn_sticky_q, an.headset, an.noise_gate};
  wire [7:0] pin_reg = {ctrl_q[7:2], pin_in, ctrl_q[csf_pkg::GPO_BIT]};
  wire [7:0] rd_mux = hit_short ? short_reg :
                      hit_rt ? rt_reg :
                      hit_pin ? pin_reg :
                      hit_ist ? {4'h0, ist_q} :
                      hit_imask ? {4'h0, imask_q} : 8'h00;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) RDATA <= 8'h00;
    else RDATA <= RD ? rd_mux : 8'h00;
  end

  // clock dividers on the clock mux output
  logic [2:0] div_q;
  logic mux_clk_q;
  wire mux_rise = mux_clk && !mux_clk_q;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div_q <= '0;
      mux_clk_q <= 1'b0;
    end else begin
      mux_clk_q <= mux_clk;
      if (mux_rise) div_q <= div_q + 3'h1;
    end
  end

  // interrupt source selection
  wire int_short = short_any;
  wire int_noise = noise_any;
  wire int_btn = an.button; // follows debounced press, active high
  wire int_hs = an.headset;
  logic int_src;
  always_comb begin
    unique case (fn)
      csf_pkg::FN_SHORT_INT: int_src = int_short;
      csf_pkg::FN_NOISE_INT: int_src = int_noise;
      csf_pkg::FN_BUTTON_INT: int_src = int_btn;
      csf_pkg::FN_HEADSET_INT: int_src = int_hs;
      csf_pkg::FN_HS_OR_BTN: int_src = int_hs | int_btn;
      csf_pkg::FN_ALL_INT: int_src = int_hs | int_btn | int_short | int_noise;
      default: int_src = 1'b0;
    endcase
  end
  // the button code passes the level straight through; the other codes are shaped
  wire shaped_sel = fn == csf_pkg::FN_SHORT_INT || fn == csf_pkg::FN_NOISE_INT ||
                    fn == csf_pkg::FN_HEADSET_INT || fn == csf_pkg::FN_HS_OR_BTN ||
                    fn == csf_pkg::FN_ALL_INT;

  // pulse shaper: one pulse, or repeating pulses until the flags register read
  logic src_q, pend_q, pulse_q;
  logic [31:0] pcnt_q;
  wire src_rise = int_src && !src_q;
  wire cont = ctrl_q[csf_pkg::DUR_BIT];
  wire pcnt_done = pcnt_q == 32'(PULSE_CYCLES - 1);
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      src_q <= 1'b0;
      pend_q <= 1'b0;
      pulse_q <= 1'b0;
      pcnt_q <= '0;
    end else begin
      src_q <= int_src;
      if (src_rise && cont) pend_q <= 1'b1;
      else if (rd_int_flags) pend_q <= 1'b0;
      if (src_rise && !pulse_q) begin
        pulse_q <= 1'b1;
        pcnt_q <= '0;
      end else if (pcnt_done) begin
        pcnt_q <= '0;
        pulse_q <= pend_q && !rd_int_flags ? ~pulse_q : 1'b0;
      end else if (pulse_q || pend_q) begin
        pcnt_q <= pcnt_q + 32'h1;
      end
    end
  end

  // pin drive selection
  logic pin_o_d, pin_oe_d;
  always_comb begin
    pin_o_d = 1'b0;
    pin_oe_d = 1'b1;
    unique case (fn)
      csf_pkg::FN_DISABLED: pin_oe_d = 1'b0;
      csf_pkg::FN_CONV_WCLK: pin_o_d = conv_wclk;
      csf_pkg::FN_DIV1: pin_o_d = mux_clk;
      csf_pkg::FN_DIV2: pin_o_d = div_q[0];
      csf_pkg::FN_DIV4: pin_o_d = div_q[1];
      csf_pkg::FN_DIV8: pin_o_d = div_q[2];
      csf_pkg::FN_GP_IN: pin_oe_d = 1'b0;
      csf_pkg::FN_GP_OUT: pin_o_d = ctrl_q[csf_pkg::GPO_BIT];
      csf_pkg::FN_BUS_WCLK: begin
        pin_oe_d = ctrl_q[csf_pkg::WCLK_DIR_BIT];
        pin_o_d = bus_wclk;
      end
      csf_pkg::FN_BUTTON_INT: pin_o_d = int_btn;
      default: pin_o_d = shaped_sel ? pulse_q : 1'b0;
    endcase
  end

  wire irq_d = |(ist_q & imask_q);
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PIN1_O <= 1'b0;
      PIN1_OE <= 1'b0;
      BUS_WCLK_OUT <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      PIN1_O <= pin_o_d;
      PIN1_OE <= pin_oe_d;
      BUS_WCLK_OUT <= fn == csf_pkg::FN_BUS_WCLK && !ctrl_q[csf_pkg::WCLK_DIR_BIT] && pin_in;
      IRQ <= irq_d;
    end
  end

  // checks
  btn_sticky_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(an.button) |=> btn_sticky_q)
    else $error("button flag not set");
  btn_clear_read_a: assert property (@(posedge CLOCK) disable iff (RST)
    btn_sticky_q && !rd_btn_clr && !an.button |=> btn_sticky_q)
    else $error("button flag lost without read");
  reserved_zero_a: assert property (@(posedge CLOCK) disable iff (RST)
    RD && hit_short |=> RDATA[1:0] == 2'b00)
    else $error("reserved bits not zero");
  short_read_a: assert property (@(posedge CLOCK) disable iff (RST)
    RD && hit_short |=> RDATA[7:4] == $past(an.short_det))
    else $error("short status mismatch");
  rt_read_a: assert property (@(posedge CLOCK) disable iff (RST)
    RD && hit_rt |=> RDATA[1:0] == $past(an.noise_gate) && RDATA[2] == $past(an.headset))
    else $error("realtime flags mismatch");
  pin_off_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_DISABLED |=> !PIN1_OE)
    else $error("disabled pin driven");
  gp_out_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_GP_OUT |=> PIN1_OE && PIN1_O == $past(ctrl_q[csf_pkg::GPO_BIT]))
    else $error("gpo not driven");
  ro_write_a: assert property (@(posedge CLOCK) disable iff (RST)
    WR && hit_rt |=> $stable(btn_sticky_q) || $past(an.button))
    else $error("write touched flags");
  irq_mask_a: assert property (@(posedge CLOCK) disable iff (RST)
    |(ist_q & imask_q) |=> IRQ)
    else $error("irq not raised");
  irq_low_a: assert property (@(posedge CLOCK) disable iff (RST)
    (ist_q & imask_q) == 4'h0 |=> !IRQ)
    else $error("irq raised with nothing pending");
  ist_set_a: assert property (@(posedge CLOCK) disable iff (RST)
    rise != 4'h0 |=> (ist_q & $past(rise)) == $past(rise))
    else $error("event not latched");
  ist_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
    wr_ist && rise == 4'h0 |=> (ist_q & $past(WDATA[3:0])) == 4'h0)
    else $error("status bit not cleared");
  rdata_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
    !RD |=> RDATA == 8'h00)
    else $error("read data without read");

  // register contents seen by the host
  short_power_a: assert property (@(posedge CLOCK) disable iff (RST)
    RD && hit_short |=> RDATA[3:2] == {$past(an.left_common_power), $past(an.right_common_power)})
    else $error("power status mismatch");
  rt_short_a: assert property (@(posedge CLOCK) disable iff (RST)
    RD && hit_rt |=> RDATA[7:4] == $past(an.short_det))
    else $error("realtime short mismatch");
  rt_button_a: assert property (@(posedge CLOCK) disable iff (RST)
    RD && hit_rt |=> RDATA[3] == $past(btn_sticky_q))
    else $error("realtime button mismatch");
  btn_read_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
    btn_sticky_q && rd_btn_clr && !an.button |=> !btn_sticky_q)
    else $error("button flag not cleared by read");
  btn_no_set_a: assert property (@(posedge CLOCK) disable iff (RST)
    !btn_sticky_q && !an.button |=> !btn_sticky_q)
    else $error("button flag set without press");
  pin_rd_a: assert property (@(posedge CLOCK) disable iff (RST)
    RD && hit_pin |=> RDATA[1] == $past(pin_in))
    else $error("pin input value mismatch");
  ctrl_write_a: assert property (@(posedge CLOCK) disable iff (RST)
    wr_pin |=> fn == $past(WDATA[7:4]))
    else $error("pin function not written");

  // pin selector
  conv_wclk_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_CONV_WCLK |=> PIN1_OE && PIN1_O == $past(conv_wclk))
    else $error("converter word clock not on pin");
  div1_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_DIV1 |=> PIN1_OE && PIN1_O == $past(mux_clk))
    else $error("divide by one mismatch");
  div2_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_DIV2 |=> PIN1_OE && PIN1_O == $past(div_q[0]))
    else $error("divide by two mismatch");
  div4_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_DIV4 |=> PIN1_OE && PIN1_O == $past(div_q[1]))
    else $error("divide by four mismatch");
  div8_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_DIV8 |=> PIN1_OE && PIN1_O == $past(div_q[2]))
    else $error("divide by eight mismatch");
  div_step_a: assert property (@(posedge CLOCK) disable iff (RST)
    mux_rise |=> div_q == $past(div_q) + 3'h1)
    else $error("divider did not advance");
  short_int_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_SHORT_INT |=> PIN1_OE && PIN1_O == $past(pulse_q))
    else $error("short interrupt not on pin");
  gp_in_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_GP_IN |=> !PIN1_OE)
    else $error("input pin driven");
  bus_wclk_dir_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_BUS_WCLK |=> PIN1_OE == $past(ctrl_q[csf_pkg::WCLK_DIR_BIT]))
    else $error("word clock direction mismatch");
  bus_wclk_in_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_BUS_WCLK && !ctrl_q[csf_pkg::WCLK_DIR_BIT] |=> BUS_WCLK_OUT == $past(pin_in))
    else $error("received word clock mismatch");
  btn_int_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_BUTTON_INT |=> PIN1_OE && PIN1_O == $past(an.button))
    else $error("button interrupt not on pin");
  hs_or_btn_src_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_HS_OR_BTN |-> int_src == (an.headset | an.button))
    else $error("headset or button source mismatch");
  all_src_a: assert property (@(posedge CLOCK) disable iff (RST)
    fn == csf_pkg::FN_ALL_INT |-> int_src == (an.headset | an.button | short_any | noise_any))
    else $error("combined source mismatch");

  // pulse shaper: a read of the flags register only stops the repeat, never cuts a pulse short
  pulse_start_a: assert property (@(posedge CLOCK) disable iff (RST)
    src_rise && !pulse_q |=> pulse_q)
    else $error("pulse not started");
  pulse_end_a: assert property (@(posedge CLOCK) disable iff (RST)
    pulse_q && pcnt_done && !pend_q |=> !pulse_q)
    else $error("single pulse did not end");
  pulse_repeat_a: assert property (@(posedge CLOCK) disable iff (RST)
    src_rise && cont |=> pend_q)
    else $error("repeat not armed");
  pend_stop_a: assert property (@(posedge CLOCK) disable iff (RST)
    rd_int_flags && !(src_rise && cont) |=> !pend_q)
    else $error("repeat not stopped by read");
endmodule : csf_top

// [csf_host.sv]
// host controller model that drives the register port
`timescale 1ns/10ps
module csf_host (
  // clock
  input wire logic clock,
  // register port
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    // reserved low bits of the short status byte are never written
    wdata <= (a == csf_pkg::ADDR_SHORT_STATUS) ? (d & 8'hFC) : d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    // released bus shows the inverse, not a stale copy
    addr <= ~a;
    wdata <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : read_reg
endmodule : csf_host

// [tb_top.sv]
// testbench for the status flags and pin one selector
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam int TIMEOUT = 20000;
  logic CLOCK;
  logic RST;
  logic [7:0] ADDR;
  logic [7:0] WDATA;
  logic WR;
  logic RD;
  logic [7:0] RDATA;
  csf_pkg::csf_analog_t ANALOG;
  logic CLOCK_MUX_IN;
  logic CONV_WCLK_IN;
  logic BUS_WCLK_IN;
  logic pin_ext;
  wire logic PIN1_I;
  logic PIN1_O;
  logic PIN1_OE;
  logic BUS_WCLK_OUT;
  logic IRQ;
  logic [15:0] cyc = 16'h0000;
  int n_mismatch = 0;
  int n_checks = 0;
  // wire level: the device wins while it drives
  assign PIN1_I = PIN1_OE ? PIN1_O : pin_ext;
  csf_top #(.PULSE_CYCLES(8)) csf_top_inst (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .ANALOG(ANALOG), .CLOCK_MUX_IN(CLOCK_MUX_IN), .CONV_WCLK_IN(CONV_WCLK_IN),
    .BUS_WCLK_IN(BUS_WCLK_IN), .PIN1_I(PIN1_I), .PIN1_O(PIN1_O), .PIN1_OE(PIN1_OE),
    .BUS_WCLK_OUT(BUS_WCLK_OUT), .IRQ(IRQ));
  csf_host csf_host_inst (.clock(CLOCK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA));
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  // slow source clocks kept well under the sampling rate of the synchronisers
  always @(posedge CLOCK) begin
    cyc <= cyc + 16'h0001;
    CLOCK_MUX_IN <= cyc[3];
    CONV_WCLK_IN <= cyc[4];
    BUS_WCLK_IN <= cyc[5];
    if (cyc == TIMEOUT[15:0]) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic settle();
    repeat (6) @(posedge CLOCK);
    #1;
  endtask : settle
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    csf_host_inst.read_reg(a, d);
    `CHK(d, e)
  endtask : chk_reg
  task automatic set_pin(input logic [7:0] v);
    csf_host_inst.write_reg(csf_pkg::ADDR_PIN1_CTRL, v);
    settle();
  endtask : set_pin
  // edges of the pin over a fixed window, one count of slack for phase
  task automatic count_edges(input logic [3:0] code, input int e);
    int n;
    logic prev;
    n = 0;
    set_pin({code, 4'h8});
    prev = PIN1_O;
    repeat (512) begin
      @(posedge CLOCK);
      #1;
      if (PIN1_O !== prev) n++;
      prev = PIN1_O;
    end
    `CHK(PIN1_OE, 1'b1)
    `CHK((n >= e - 1) && (n <= e + 1), 1'b1)
  endtask : count_edges
  // cycles with the pin high over a window
  task automatic count_high(input int w, output int n);
    n = 0;
    repeat (w) begin
      @(posedge CLOCK);
      #1;
      if (PIN1_O === 1'b1) n++;
    end
  endtask : count_high
  // sources low while the code is set, so the event gives a clean rising edge
  task automatic pulse_test(input logic [7:0] ctl, input csf_pkg::csf_analog_t ev, input int w, output int n);
    ANALOG <= '0;
    set_pin(ctl);
    ANALOG <= ev;
    count_high(w, n);
  endtask : pulse_test
  initial begin
    int n;
    RST = 1'b1;
    ANALOG = '0;
    pin_ext = 1'b0;
    repeat (4) @(posedge CLOCK);
    RST <= 1'b0;
    chk_reg(csf_pkg::ADDR_SHORT_STATUS, 8'h00);
    chk_reg(csf_pkg::ADDR_RT_FLAGS, 8'h00);
    chk_reg(csf_pkg::ADDR_PIN1_CTRL, 8'h00);
    `CHK(PIN1_OE, 1'b0)
    ANALOG <= 10'h2A9;
    settle();
    chk_reg(csf_pkg::ADDR_SHORT_STATUS, 8'hA8);
    chk_reg(csf_pkg::ADDR_RT_FLAGS, 8'hA5);
    csf_host_inst.write_reg(csf_pkg::ADDR_SHORT_STATUS, 8'h00);
    csf_host_inst.write_reg(csf_pkg::ADDR_RT_FLAGS, 8'hFF);
    chk_reg(csf_pkg::ADDR_SHORT_STATUS, 8'hA8);
    chk_reg(csf_pkg::ADDR_RT_FLAGS, 8'hA5);
    chk_reg(8'h3C, 8'h00);
    ANALOG.noise_gate <= 2'h2;
    ANALOG.button <= 1'b1;
    set_pin({csf_pkg::FN_BUTTON_INT, 4'h0});
    `CHK({PIN1_OE, PIN1_O}, 2'h3)
    ANALOG.button <= 1'b0;
    settle();
    `CHK(PIN1_O, 1'b0)
    chk_reg(csf_pkg::ADDR_RT_FLAGS, 8'hAE);
    chk_reg(csf_pkg::ADDR_RT_FLAGS, 8'hAE);
    chk_reg(csf_pkg::ADDR_BUTTON_CLEAR, 8'h00);
    chk_reg(csf_pkg::ADDR_RT_FLAGS, 8'hA6);
    // event latch and mask path to the interrupt line
    chk_reg(csf_pkg::ADDR_INT_STATUS, 8'h0F);
    `CHK(IRQ, 1'b0)
    csf_host_inst.write_reg(csf_pkg::ADDR_INT_MASK, 8'h04);
    settle();
    `CHK(IRQ, 1'b1)
    csf_host_inst.write_reg(csf_pkg::ADDR_INT_STATUS, 8'h0F);
    settle();
    `CHK(IRQ, 1'b0)
    chk_reg(csf_pkg::ADDR_INT_STATUS, 8'h00);
    set_pin(8'h91);
    `CHK({PIN1_OE, PIN1_O}, 2'h3)
    set_pin(8'h90);
    `CHK({PIN1_OE, PIN1_O}, 2'h2)
    pin_ext <= 1'b1;
    set_pin(8'h80);
    `CHK(PIN1_OE, 1'b0)
    chk_reg(csf_pkg::ADDR_PIN1_CTRL, 8'h82);
    set_pin(8'h00);
    `CHK(PIN1_OE, 1'b0)
    for (int i = 0; i < 4; i++) begin
      count_edges(csf_pkg::FN_DIV1 + 4'(i), 64 >> i);
    end
    count_edges(csf_pkg::FN_CONV_WCLK, 32);
    count_edges(csf_pkg::FN_BUS_WCLK, 16);
    set_pin({csf_pkg::FN_BUS_WCLK, 4'h0});
    `CHK({PIN1_OE, BUS_WCLK_OUT}, 2'h1)
    pin_ext <= 1'b0;
    settle();
    `CHK(BUS_WCLK_OUT, 1'b0)
    pulse_test({csf_pkg::FN_SHORT_INT, 4'h0}, 10'h040, 40, n);
    `CHK(n, 8)
    pulse_test({csf_pkg::FN_NOISE_INT, 4'h0}, 10'h001, 40, n);
    `CHK(n, 8)
    pulse_test({csf_pkg::FN_HEADSET_INT, 4'h0}, 10'h008, 40, n);
    `CHK(n, 8)
    pulse_test({csf_pkg::FN_HS_OR_BTN, 4'h0}, 10'h004, 40, n);
    `CHK(n, 8)
    pulse_test({csf_pkg::FN_ALL_INT, 4'h0}, 10'h040, 40, n);
    `CHK(n, 8)
    pulse_test({csf_pkg::FN_ALL_INT, 4'h4}, 10'h001, 64, n);
    `CHK((n >= 24) && (n <= 40), 1'b1)
    chk_reg(csf_pkg::ADDR_INT_FLAGS_READ, 8'h00);
    count_high(20, n);
    count_high(40, n);
    `CHK(n, 0)
    report_and_stop();
  end
endmodule : tb_top
